//--- core/bk1_pkg.sv
// constants for the first step-down channel control register bank
// assumes a byte-wide register port fed by the device's serial slave engine
`default_nettype none
package bk1_pkg;
  // register offsets
  localparam logic [7:0] VOLT_OFFSET = 8'h10;
  localparam logic [7:0] MODE_OFFSET = 8'h11;
  localparam logic [7:0] TRIM_OFFSET = 8'h12;
  localparam logic [7:0] STAT_OFFSET = 8'h13;
  // field positions
  localparam int RANGE_BIT  = 6;
  localparam int MODE_BIT   = 0;
  localparam int PGOOD_BIT  = 1;
  // values after reset
  localparam logic [5:0] CODE_RESET  = 6'h00;
  localparam logic       RANGE_RESET = 1'b1;
  localparam logic       MODE_RESET  = 1'b0;
  localparam logic [1:0] TRIM_RESET  = 2'h0;
  localparam logic [2:0] STAT_RESET  = 3'h0;
  // fill for read-only bits, which differ from part to part
  localparam logic       RO_VOLT_FILL = 1'b0;
  localparam logic [6:0] RO_MODE_FILL = 7'h00;
  localparam logic [5:0] RO_TRIM_FILL = 6'h00;
  localparam logic       RO_STAT3_FILL = 1'b0;
  localparam logic [2:0] RO_STATHI_FILL = 3'h0;
  // voltage decode figures in millivolts
  localparam logic [12:0] MV_HIGH_BASE = 13'h04E2;
  localparam logic [12:0] MV_HIGH_STEP = 13'h0032;
  localparam logic [12:0] MV_LOW_STEP  = 13'h0019;
  localparam logic [12:0] MV_L1_BASE   = 13'h044C;
  localparam logic [12:0] MV_L1_UPPER  = 13'h04E7;
  localparam logic [12:0] MV_L2_BASE   = 13'h05AF;
  localparam logic [12:0] MV_L2_UPPER  = 13'h0631;
  localparam logic [12:0] MV_L3_FIRST  = 13'h0744;
  localparam logic [12:0] MV_L3_BASE   = 13'h0762;
  localparam logic [12:0] MV_L3_14     = 13'h0898;
  localparam logic [12:0] MV_L3_15     = 13'h08C5;
  // power-good threshold, percent of nominal
  localparam logic [19:0] PG_PERCENT   = 20'h0005E;
  localparam logic [19:0] FULL_PERCENT = 20'h00064;
  // read answer latency in cycles
  localparam int READ_LATENCY = 1;
endpackage
`default_nettype wire

//--- core/bk1_regs.sv
// register bank and voltage decode for the first step-down channel
// assumes the serial slave engine issues one-cycle byte read/write strobes
// and that SENSE_MV is a synchronous output-voltage measurement in mV
`default_nettype none
module bk1_regs
  import bk1_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  output logic             REG_RVALID,
  input  wire logic [12:0] SENSE_MV,
  output logic      [5:0]  OUTPUT_VOLTAGE_CODE,
  output logic             VOLTAGE_RANGE_SELECT,
  output logic      [12:0] TARGET_MV,
  output logic             CODE_NOT_AVAILABLE,
  output logic             AUTO_LIGHT_LOAD_OPERATION,
  output logic             POWER_GOOD
);
  import bk1_pkg::*;

  logic [5:0]  code;
  logic        range_sel;
  logic        forced_pwm;
  logic [1:0]  trim_we;
  logic [2:0]  stat_we;
  logic        pgood;
  logic [12:0] target;
  logic [7:0]  rdata;
  logic        rvalid;

  // returns zero for codes that are not available
  function automatic logic [12:0] bk1_decode(input logic rng, input logic [5:0] c);
    logic [12:0] i;
    logic [12:0] mv;
    begin
      i = {9'h000, c[3:0]};
      mv = 13'h0000;
      if (rng)
      begin
        mv = MV_HIGH_BASE + 13'(MV_HIGH_STEP * {7'h00, c});
      end
      else
      begin
        case (c[5:4])
          2'h1:
          begin
            if (i < 13'h0002)
              mv = 13'h0000;
            else if (i < 13'h0008)
              mv = MV_L1_BASE + 13'(MV_LOW_STEP * (i - 13'h0002));
            else
              mv = MV_L1_UPPER + 13'(MV_LOW_STEP * (i - 13'h0008));
          end
          2'h2:
          begin
            if (i < 13'h0005)
              mv = MV_L2_BASE + 13'(MV_LOW_STEP * i);
            else
              mv = MV_L2_UPPER + 13'(MV_LOW_STEP * (i - 13'h0005));
          end
          2'h3:
          begin
            if (i == 13'h0000)
              mv = MV_L3_FIRST;
            else if (i == 13'h000E)
              mv = MV_L3_14;
            else if (i == 13'h000F)
              mv = MV_L3_15;
            else
              mv = MV_L3_BASE + 13'(MV_LOW_STEP * (i - 13'h0001));
          end
          default:
            mv = 13'h0000;
        endcase
      end
      bk1_decode = mv;
    end
  endfunction

  // decode of the register port
  wire wr_volt = REG_WR && (REG_ADDR == VOLT_OFFSET);
  wire wr_mode = REG_WR && (REG_ADDR == MODE_OFFSET);
  wire wr_trim = REG_WR && (REG_ADDR == TRIM_OFFSET);
  wire wr_stat = REG_WR && (REG_ADDR == STAT_OFFSET);

  wire [7:0] rd_volt = {RO_VOLT_FILL, range_sel, code};
  wire [7:0] rd_mode = {RO_MODE_FILL, forced_pwm};
  wire [7:0] rd_trim = {trim_we, RO_TRIM_FILL};
  wire [7:0] rd_stat = {RO_STATHI_FILL, stat_we[2], RO_STAT3_FILL,
                        stat_we[1], pgood, stat_we[0]};

  // full byte select; unmapped reads answer zero
  wire [7:0] next_rdata = (REG_ADDR == VOLT_OFFSET) ? rd_volt :
                          (REG_ADDR == MODE_OFFSET) ? rd_mode :
                          (REG_ADDR == TRIM_OFFSET) ? rd_trim :
                          (REG_ADDR == STAT_OFFSET) ? rd_stat : 8'h00;

  wire [12:0] next_target = bk1_decode(range_sel, code);

  // compare scaled to avoid a divider: sense*100 >= nominal*94
  wire [19:0] sense_scaled = 20'(FULL_PERCENT * {7'h00, SENSE_MV});
  wire [19:0] thresh_scaled = 20'(PG_PERCENT * {7'h00, target});
  // an unavailable code has no nominal, so it never reports good
  wire next_pgood = (target != 13'h0000) && (sense_scaled >= thresh_scaled);

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      code      <= CODE_RESET;
      range_sel <= RANGE_RESET;
    end
    else if (wr_volt)
    begin
      code      <= REG_WDATA[5:0];
      range_sel <= REG_WDATA[RANGE_BIT];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      forced_pwm <= MODE_RESET;
    else if (wr_mode)
      forced_pwm <= REG_WDATA[MODE_BIT];
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      trim_we <= TRIM_RESET;
      stat_we <= STAT_RESET;
    end
    else
    begin
      if (wr_trim)
        trim_we <= REG_WDATA[7:6];
      if (wr_stat)
        stat_we <= {REG_WDATA[4], REG_WDATA[2], REG_WDATA[0]};
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      target <= 13'h0000;
      pgood  <= 1'b0;
    end
    else
    begin
      target <= next_target;
      pgood  <= next_pgood;
    end
  end

  // one byte answered per read strobe
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= REG_RD;
      if (REG_RD)
        rdata <= next_rdata;
    end
  end

  assign REG_RDATA = rdata;
  assign REG_RVALID = rvalid;
  assign OUTPUT_VOLTAGE_CODE = code;
  assign VOLTAGE_RANGE_SELECT = range_sel;
  assign TARGET_MV = target;
  assign CODE_NOT_AVAILABLE = (target == 13'h0000);
  assign AUTO_LIGHT_LOAD_OPERATION = ~forced_pwm;
  assign POWER_GOOD = pgood;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence write_to(logic [7:0] a);
    REG_WR && REG_ADDR == a;
  endsequence

  sequence read_from(logic [7:0] a);
    REG_RD && REG_ADDR == a && !REG_WR;
  endsequence

  // write, one idle cycle, then read back the same byte
  sequence write_then_read(logic [7:0] a);
    write_to(a) ##1 !REG_WR ##1 read_from(a);
  endsequence

  code_write_a: assert property (
    write_to(VOLT_OFFSET) |=> code == $past(REG_WDATA[5:0]))
    else $error("voltage code not stored");

  range_write_a: assert property (
    write_to(VOLT_OFFSET) |=> range_sel == $past(REG_WDATA[6]))
    else $error("range bit not stored");

  high_range_a: assert property (
    range_sel && $stable(code) && $stable(range_sel) |=>
      target == 13'(MV_HIGH_BASE + 13'(MV_HIGH_STEP * {7'h00, $past(code)})))
    else $error("high range target wrong");

  low_edge_a: assert property (
    !range_sel && code == 6'h12 ##1 !range_sel && code == 6'h12 |->
      target == MV_L1_BASE ##1 !CODE_NOT_AVAILABLE || $changed(code))
    else $error("low range first code wrong");

  low_na_a: assert property (
    (!range_sel && code < 6'h12) [*2] |-> CODE_NOT_AVAILABLE)
    else $error("unavailable code not flagged");

  mode_write_a: assert property (
    write_to(MODE_OFFSET) |=> AUTO_LIGHT_LOAD_OPERATION == !$past(REG_WDATA[0]))
    else $error("mode bit not stored");

  pg_read_a: assert property (
    read_from(STAT_OFFSET) |=> REG_RVALID && REG_RDATA[PGOOD_BIT] == $past(pgood))
    else $error("power good not readable");

  pg_thresh_a: assert property (
    target != 13'h0000 && sense_scaled >= thresh_scaled |=> POWER_GOOD)
    else $error("power good threshold missed");

  ro_keep_a: assert property (
    read_from(MODE_OFFSET) |=> REG_RDATA[7:1] == RO_MODE_FILL)
    else $error("read-only bits changed");

  we_store_a: assert property (
    write_then_read(TRIM_OFFSET) |=> REG_RDATA[7:6] == $past(REG_WDATA[7:6], 3))
    else $error("write-exact bits lost");

  rd_once_a: assert property (
    REG_RD |=> REG_RVALID ##1 (REG_RVALID == $past(REG_RD)))
    else $error("read answer timing wrong");

  rd_full_a: assert property (
    read_from(VOLT_OFFSET) |=> REG_RDATA == {RO_VOLT_FILL, $past(range_sel), $past(code)})
    else $error("read value incomplete");

  low_top_a: assert property (
    (!range_sel && code == 6'h3F) [*2] |-> target == MV_L3_15)
    else $error("low range top code wrong");

  na_not_good_a: assert property (
    CODE_NOT_AVAILABLE |=> !POWER_GOOD)
    else $error("unavailable code reported good");

  mode_read_a: assert property (
    read_from(MODE_OFFSET) |=> REG_RDATA[MODE_BIT] == !AUTO_LIGHT_LOAD_OPERATION)
    else $error("mode bit read wrong");

  volt_ro_a: assert property (
    read_from(VOLT_OFFSET) |=> REG_RDATA[7] == RO_VOLT_FILL)
    else $error("voltage read-only bit wrong");

  trim_ro_a: assert property (
    read_from(TRIM_OFFSET) |=> REG_RDATA[5:0] == RO_TRIM_FILL)
    else $error("trim read-only bits wrong");

  stat_ro_a: assert property (
    read_from(STAT_OFFSET) |=>
      REG_RDATA[7:5] == RO_STATHI_FILL && REG_RDATA[3] == RO_STAT3_FILL)
    else $error("status read-only bits wrong");

  stat_we_a: assert property (
    write_then_read(STAT_OFFSET) |=> REG_RDATA[4] == $past(REG_WDATA[4], 3) &&
      REG_RDATA[2] == $past(REG_WDATA[2], 3) && REG_RDATA[0] == $past(REG_WDATA[0], 3))
    else $error("status write-exact bits lost");

  unmapped_rd_a: assert property (
    REG_RD && (REG_ADDR < VOLT_OFFSET || REG_ADDR > STAT_OFFSET) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");

  rd_idle_a: assert property (
    !REG_RD |=> !REG_RVALID && $stable(REG_RDATA))
    else $error("read answer without a read");
endmodule
`default_nettype wire

//--- verification/bk1_host.sv
// host model issuing single-byte register strobes
// assumes the bank samples strobes on the rising clock edge
`default_nettype none
module bk1_host (
  input  wire logic       clk,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr_en,
  output logic            rd_en
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // host writes defaults
  // after each write strobe the host leaves the inverted address and data on the bus; after a read, only the inverted address
  // single byte write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    wdata <= ~d;
    addr  <= ~a;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    addr  <= ~a;
  endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the channel one register bank
// assumes bk1_host drives all register strobes
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bk1_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [12:0] sense = 13'h0000;
  logic [7:0]  addr, wdata, rdata;
  logic        wr_en, rd_en, rvalid, range, na, autol, pg;
  logic [5:0]  vcode, code;
  logic [12:0] tgt;
  logic [7:0]  exp_q[$];
  int          num_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          seed = 5123;
  logic [5:0]  lo_code [9] = '{6'h00, 6'h11, 6'h12, 6'h17, 6'h18, 6'h25, 6'h30, 6'h3E, 6'h3F};
  logic [12:0] lo_mv [9] = '{13'h0000, 13'h0000, 13'h044C, 13'h04C9, 13'h04E7, 13'h0631,
                             13'h0744, 13'h0898, 13'h08C5};
  bk1_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en));
  bk1_regs uut (.CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WR(wr_en), .REG_WDATA(wdata),
    .REG_RD(rd_en), .REG_RDATA(rdata), .REG_RVALID(rvalid), .SENSE_MV(sense),
    .OUTPUT_VOLTAGE_CODE(vcode), .VOLTAGE_RANGE_SELECT(range), .TARGET_MV(tgt),
    .CODE_NOT_AVAILABLE(na), .AUTO_LIGHT_LOAD_OPERATION(autol), .POWER_GOOD(pg));
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [12:0] seen, input logic [12:0] want);
    checks_done++;
    if (seen !== want)
    begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // each read answer is matched against the oldest note
  always @(negedge clk)
    if (rvalid === 1'b1)
      check({5'h00, rdata}, (exp_q.size() > 0) ? {5'h00, exp_q.pop_front()} : 13'h1FFF);
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      close_out();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd_chk(VOLT_OFFSET, 8'h40);
    rd_chk(MODE_OFFSET, 8'h00);
    rd_chk(TRIM_OFFSET, 8'h00);
    rd_chk(STAT_OFFSET, 8'h00);
    rd_chk(8'h14, 8'h00);
    host.wr(VOLT_OFFSET, 8'hC5);
    rd_chk(VOLT_OFFSET, 8'h45);
    check(tgt, 13'h05DC);
    for (int i = 0; i < 8; i++)
    begin
      code = (i == 0) ? 6'h3F : 6'($random(seed));
      host.wr(VOLT_OFFSET, {2'b01, code});
      wait_n(1);
      check(tgt, 13'h04E2 + 13'h0032 * code);
      check({6'h00, range, vcode}, {7'h01, code});
    end
    for (int i = 0; i < 9; i++)
    begin
      host.wr(VOLT_OFFSET, {2'b00, lo_code[i]});
      wait_n(1);
      check(tgt, lo_mv[i]);
      check({12'h000, na}, {12'h000, lo_mv[i] == 13'h0000});
    end
    host.wr(MODE_OFFSET, 8'hFF);
    rd_chk(MODE_OFFSET, 8'h01);
    check({12'h000, autol}, 13'h0000);
    host.wr(MODE_OFFSET, 8'hFE);
    rd_chk(MODE_OFFSET, 8'h00);
    check({12'h000, autol}, 13'h0001);
    host.wr(TRIM_OFFSET, 8'hFF);
    rd_chk(TRIM_OFFSET, 8'hC0);
    host.wr(TRIM_OFFSET, 8'h00);
    // unavailable code never counts as good
    host.wr(VOLT_OFFSET, 8'h01);
    sense <= 13'h1000;
    wait_n(2);
    check({12'h000, pg}, 13'h0000);
    host.wr(VOLT_OFFSET, 8'h40);
    sense <= 13'h0497;
    wait_n(2);
    check({12'h000, pg}, 13'h0001);
    host.wr(STAT_OFFSET, 8'hFF);
    rd_chk(STAT_OFFSET, 8'h17);
    host.wr(STAT_OFFSET, 8'h00);
    sense <= 13'h0496;
    wait_n(2);
    check({12'h000, pg}, 13'h0000);
    rd_chk(STAT_OFFSET, 8'h00);
    // a reset in mid-run must bring back the power-up values
    repeat (2) @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd_chk(VOLT_OFFSET, 8'h40);
    rd_chk(TRIM_OFFSET, 8'h00);
    rd_chk(STAT_OFFSET, 8'h00);
    wait_n(2);
    check(13'(exp_q.size()), 13'h0000);
    close_out();
  end
endmodule
`default_nettype wire
